/* sat_defs.vh */
`ifndef SAT_DEFS_VH
`define SAT_DEFS_VH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define SAT_START_BYTE 8'h02
`define SAT_CMD_READ_REQ 8'h10
`define SAT_CMD_WRITE_REQ 8'h11
`define SAT_CNF_BIT 8'h40
`define SAT_STATUS_OK 8'h00
`define SAT_STATUS_FAIL 8'h01

// ----------------------------------------
// settings
// ----------------------------------------
`define SAT_IDX_PROFILE 8'h09
`define SAT_IDX_FACTOR 8'h0A
`define SAT_PROFILE_RESET 8'h01
`define SAT_PROFILE_MAX 8'h0B
`define SAT_FACTOR_RESET 8'h02
`define SAT_FACTOR_MIN 8'h01
`define SAT_FACTOR_MAX 8'h0A
`define SAT_WRITE_LEN 16'h0002
`define SAT_READ_LEN 16'h0001

// ----------------------------------------
// timing
// ----------------------------------------
`define SAT_CLK_HZ 20000000
`define SAT_TICK_MS 1
`define SAT_MS_PER_S 16'h03E8
// profile 11 in the top entry, profile 0 in the bottom entry
`define SAT_ADV_MS_TABLE {16'h2800, 16'h1388, 16'h07D0, 16'h03E8, 16'h01F4, 16'h00FA, 16'h0078, 16'h0064, 16'h0050, 16'h003C, 16'h0028, 16'h0014}
`define SAT_WIN_MS_TABLE {16'h2800, 16'h186A, 16'h09C4, 16'h04E2, 16'h0258, 16'h0138, 16'h0096, 16'h0078, 16'h0064, 16'h0050, 16'h0032, 16'h0019}
`define SAT_CONN_S_TABLE {8'h23, 8'h14, 8'h0A, 8'h05, 8'h04, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h01}

`endif

/* sat_frame_rx.v */
`timescale 1ns/1ps
`default_nettype none
`include "sat_defs.vh"

module sat_frame_rx (
  input wire clk,
  input wire rstn,
  input wire [7:0] in_byte,
  input wire in_take,
  output reg req_valid_q,
  output reg [7:0] req_cmd_q,
  output reg [15:0] req_len_q,
  output reg [7:0] req_index_q,
  output reg [7:0] req_param_q
);

  localparam ST_START = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_LEN_LO = 3'h2;
  localparam ST_LEN_HI = 3'h3;
  localparam ST_BODY = 3'h4;
  localparam ST_CS = 3'h5;

  reg [2:0] st_q;
  reg [7:0] cs_q;
  reg [15:0] left_q;
  reg [15:0] pos_q;

  always @(posedge clk) begin
    req_valid_q <= 1'b0;
    if (!rstn) begin
      st_q <= ST_START;
      cs_q <= 8'h00;
      left_q <= 16'h0000;
      pos_q <= 16'h0000;
      req_cmd_q <= 8'h00;
      req_len_q <= 16'h0000;
      req_index_q <= 8'h00;
      req_param_q <= 8'h00;
    end else if (in_take) begin
      cs_q <= cs_q ^ in_byte; // [R12]
      case (st_q)
        ST_START: begin
          cs_q <= in_byte;
          if (in_byte == `SAT_START_BYTE) begin
            st_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          req_cmd_q <= in_byte;
          st_q <= ST_LEN_LO;
        end
        ST_LEN_LO: begin
          left_q <= {8'h00, in_byte};
          st_q <= ST_LEN_HI;
        end
        ST_LEN_HI: begin
          req_len_q <= {in_byte, left_q[7:0]};
          left_q <= {in_byte, left_q[7:0]};
          pos_q <= 16'h0000;
          st_q <= ({in_byte, left_q[7:0]} == 16'h0000) ? ST_CS : ST_BODY;
        end
        ST_BODY: begin
          if (pos_q == 16'h0000) begin
            req_index_q <= in_byte;
          end
          if (pos_q == 16'h0001) begin
            req_param_q <= in_byte;
          end
          pos_q <= pos_q + 16'h0001;
          left_q <= left_q - 16'h0001;
          if (left_q == 16'h0001) begin
            st_q <= ST_CS;
          end
        end
        ST_CS: begin
          req_valid_q <= (in_byte == cs_q); // [R12]
          st_q <= ST_START;
        end
        default: begin
          st_q <= ST_START;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* sat_frame_tx.v */
`timescale 1ns/1ps
`default_nettype none
`include "sat_defs.vh"

module sat_frame_tx (
  input wire clk,
  input wire rstn,
  input wire start,
  input wire [7:0] cmd,
  input wire [7:0] status,
  input wire [7:0] value,
  input wire has_value,
  input wire out_ready,
  output reg out_valid_q,
  output reg [7:0] out_byte_q
);

  reg [2:0] step_q;
  reg [7:0] cs_q;
  reg [7:0] cmd_q;
  reg [7:0] status_q;
  reg [7:0] value_q;
  reg has_value_q;
  reg [7:0] nxt;
  reg [2:0] step_n;

  // ----------------------------------------
  // byte for the following step
  // ----------------------------------------
  always @* begin
    step_n = step_q + 3'h1;
    case (step_n)
      3'h1: nxt = cmd_q;
      3'h2: nxt = has_value_q ? 8'h02 : 8'h01;
      3'h3: nxt = 8'h00;
      3'h4: nxt = status_q;
      3'h5: nxt = has_value_q ? value_q : cs_q;
      default: nxt = cs_q;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      step_q <= 3'h0;
      cs_q <= 8'h00;
      cmd_q <= 8'h00;
      status_q <= 8'h00;
      value_q <= 8'h00;
      has_value_q <= 1'b0;
      out_valid_q <= 1'b0;
      out_byte_q <= 8'h00;
    end else if (!out_valid_q) begin
      if (start) begin
        cmd_q <= cmd;
        status_q <= status;
        value_q <= value;
        has_value_q <= has_value;
        step_q <= 3'h0;
        cs_q <= `SAT_START_BYTE;
        out_byte_q <= `SAT_START_BYTE;
        out_valid_q <= 1'b1;
      end
    end else if (out_ready) begin
      if (step_q == (has_value_q ? 3'h6 : 3'h5)) begin
        out_valid_q <= 1'b0;
      end else begin
        step_q <= step_n;
        out_byte_q <= nxt;
        cs_q <= cs_q ^ nxt; // [R12]
      end
    end
  end

endmodule

`default_nettype wire

/* sat_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sat_host_model (
  input wire logic clk,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  input wire logic rx_ready_q,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic [7:0] rep [$];
  initial begin
    rx_byte = 8'hFF;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // ----------------------------------------
  // reply sink, stalls every other cycle when slow
  // ----------------------------------------
  always @(posedge clk) tx_ready <= #2 !slow | !tx_ready;
  task put(input logic [7:0] b);
    begin
      rx_byte = b;
      rx_valid = 1'b1;
      @(negedge clk);
      while (!rx_ready_q) @(negedge clk);
      @(posedge clk);
      #2;
    end
  endtask
  task xfer(input logic [7:0] cmd, input logic [15:0] len, input logic [7:0] idx,
            input logic [7:0] par, input logic wpar, input logic bad);
    logic [7:0] f [$];
    logic [7:0] cs;
    integer j;
    begin
      f = '{8'h02, cmd, len[7:0], len[15:8], idx};
      if (wpar) f.push_back(par);
      cs = 8'h00;
      foreach (f[k]) cs ^= f[k];
      f.push_back(cs ^ {7'h00, bad});
      foreach (f[k]) put(f[k]);
      rx_valid = 1'b0;
      rx_byte = ~rx_byte;
      rep.delete();
      for (j = 0; j < 80; j++) begin
        @(negedge clk);
        if (tx_valid && tx_ready) rep.push_back(tx_byte);
      end
      @(posedge clk);
      #2;
    end
  endtask
endmodule
`default_nettype wire

/* sat_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sat_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic rx_ready_q,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic scan_mode,
  input wire logic conn_request,
  input wire logic conn_answer,
  input wire logic adv_send_q,
  input wire logic scan_on_q,
  input wire logic chan_switch_q,
  input wire logic conn_pending_q,
  input wire logic conn_fail_q,
  input wire logic [7:0] scan_timing_profile_q,
  input wire logic [7:0] scan_duty_factor_q
);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence idle_run;
    !scan_mode [*3];
  endsequence
  sequence scan_run;
    scan_mode [*3];
  endsequence
  reset_values_a: assert property (disable iff (1'b0) !rstn |=>
    scan_timing_profile_q == 8'h01 && scan_duty_factor_q == 8'h02 && !tx_valid)
    else $error("settings not at reset values");
  factor_range_a: assert property (scan_duty_factor_q inside {[8'h01:8'h0A]})
    else $error("factor out of range");
  profile_range_a: assert property (scan_timing_profile_q <= 8'h0B)
    else $error("profile out of range");
  adv_scan_a: assert property (scan_run |=> !adv_send_q)
    else $error("advert while scanning");
  adv_single_a: assert property (adv_send_q |=> !adv_send_q [*8])
    else $error("advert pulses too close");
  scan_idle_a: assert property (idle_run |=> !scan_on_q && !chan_switch_q)
    else $error("scan activity while idle");
  chan_single_a: assert property (chan_switch_q |=> !chan_switch_q [*8])
    else $error("channel switches too close");
  fail_cause_a: assert property (conn_fail_q |->
    $past(conn_pending_q) && !$past(conn_answer)) else $error("stray setup fail");
  req_pend_a: assert property (conn_request |=> conn_pending_q)
    else $error("request not pending");
  answer_stop_a: assert property (conn_answer && !conn_request |=> !conn_pending_q)
    else $error("answer left timer running");
  tx_start_a: assert property ($rose(tx_valid) |-> tx_byte == 8'h02)
    else $error("reply without start byte");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("reply byte dropped");
  rx_block_a: assert property (tx_valid |-> !rx_ready_q)
    else $error("request taken during reply");
endmodule
bind sat_top sat_props i_props (
  .clk(clk), .rstn(rstn), .rx_ready_q(rx_ready_q), .tx_byte(tx_byte),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .scan_mode(scan_mode),
  .conn_request(conn_request), .conn_answer(conn_answer), .adv_send_q(adv_send_q),
  .scan_on_q(scan_on_q), .chan_switch_q(chan_switch_q), .conn_pending_q(conn_pending_q),
  .conn_fail_q(conn_fail_q), .scan_timing_profile_q(scan_timing_profile_q),
  .scan_duty_factor_q(scan_duty_factor_q)
);
`default_nettype wire

/* sat_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "sat_defs.vh"

// Notes on behaviour
// (R1) The scan duty factor lives at settings index 10, takes 1 to 10, resets to 2, read and write.
// (R2) While scanning the scan interval is the duty factor times the window: scan, suspend, switch.
// (R3) The timing profile lives at settings index 9, takes 0 to 11, resets to 1, picks a timing set.
// (R4) When idle an advertising packet goes out once per profile advertising interval.
// (R5) When scanning the radio scans only during the window part of each scan interval.
// (R6) When scanning the channel switches each time one scan interval has passed.
// (R7) A connection request not answered within the profile setup timeout is reported failed.
// (R8) A write request frame is start, command 0x11, length low and high, index, parameters, checksum.
// (R9) A write is answered with command 0x51, length one, a status byte with 0x00 as success, checksum.
// (R10) A read request frame is start, command 0x10, length one, index, checksum.
// (R11) A read is answered with command 0x50, length of status plus value, status, value, checksum; a failed read gets length one and no value.
// (R12) The checksum is the xor of all earlier frame bytes, checked before a frame is acted on.
module sat_top #(
  parameter TICK_CYCLES = `SAT_CLK_HZ / 1000 * `SAT_TICK_MS
) (
  input wire clk,
  input wire rstn,
  input wire [7:0] rx_byte,
  input wire rx_valid,
  output reg rx_ready_q,
  output wire [7:0] tx_byte,
  output wire tx_valid,
  input wire tx_ready,
  input wire scan_mode,
  input wire conn_request,
  input wire conn_answer,
  output reg adv_send_q,
  output reg scan_on_q,
  output reg chan_switch_q,
  output reg conn_pending_q,
  output reg conn_fail_q,
  output reg [7:0] scan_timing_profile_q,
  output reg [7:0] scan_duty_factor_q
);

  localparam [191:0] ADV_TAB = `SAT_ADV_MS_TABLE;
  localparam [191:0] WIN_TAB = `SAT_WIN_MS_TABLE;
  localparam [95:0] CONN_TAB = `SAT_CONN_S_TABLE;

  // ----------------------------------------
  // request parsing
  // ----------------------------------------
  wire req_valid;
  wire [7:0] req_cmd;
  wire [15:0] req_len;
  wire [7:0] req_index;
  wire [7:0] req_param;
  wire rx_take;

  assign rx_take = rx_valid & rx_ready_q;

  sat_frame_rx u_rx (
    .clk(clk),
    .rstn(rstn),
    .in_byte(rx_byte),
    .in_take(rx_take),
    .req_valid_q(req_valid),
    .req_cmd_q(req_cmd),
    .req_len_q(req_len),
    .req_index_q(req_index),
    .req_param_q(req_param)
  );

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  reg is_write;
  reg is_read;
  reg write_ok;
  reg read_ok;
  reg [7:0] read_val;

  always @* begin
    is_write = req_valid && (req_cmd == `SAT_CMD_WRITE_REQ); // [R8]
    is_read = req_valid && (req_cmd == `SAT_CMD_READ_REQ); // [R10]
    write_ok = 1'b0;
    read_ok = 1'b0;
    read_val = 8'h00;
    if (req_len == `SAT_WRITE_LEN) begin
      if (req_index == `SAT_IDX_PROFILE) begin
        write_ok = (req_param <= `SAT_PROFILE_MAX); // [R3]
      end else if (req_index == `SAT_IDX_FACTOR) begin
        write_ok = (req_param >= `SAT_FACTOR_MIN) && (req_param <= `SAT_FACTOR_MAX); // [R1]
      end
    end
    if (req_len == `SAT_READ_LEN) begin
      if (req_index == `SAT_IDX_PROFILE) begin
        read_ok = 1'b1;
        read_val = scan_timing_profile_q; // [R3]
      end else if (req_index == `SAT_IDX_FACTOR) begin
        read_ok = 1'b1;
        read_val = scan_duty_factor_q; // [R1]
      end
    end
  end

  // ----------------------------------------
  // settings
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rstn) begin
      scan_timing_profile_q <= `SAT_PROFILE_RESET; // [R3]
      scan_duty_factor_q <= `SAT_FACTOR_RESET; // [R1]
    end else if (is_write && write_ok) begin
      if (req_index == `SAT_IDX_PROFILE) begin
        scan_timing_profile_q <= req_param; // [R3]
      end else begin
        scan_duty_factor_q <= req_param; // [R1]
      end
    end
  end

  // ----------------------------------------
  // confirmations
  // ----------------------------------------
  wire tx_start;
  wire [7:0] tx_cmd;
  wire [7:0] tx_status;
  wire tx_has_value;

  assign tx_start = is_write | is_read;
  assign tx_cmd = req_cmd | `SAT_CNF_BIT; // [R9] [R11]
  assign tx_status = (is_write ? write_ok : read_ok) ? `SAT_STATUS_OK : `SAT_STATUS_FAIL;
  assign tx_has_value = is_read & read_ok; // [R11]

  sat_frame_tx u_tx (
    .clk(clk),
    .rstn(rstn),
    .start(tx_start),
    .cmd(tx_cmd),
    .status(tx_status),
    .value(read_val),
    .has_value(tx_has_value),
    .out_ready(tx_ready),
    .out_valid_q(tx_valid),
    .out_byte_q(tx_byte)
  );

  // no new bytes while a confirmation is pending or being sent
  always @(posedge clk) begin
    if (!rstn) begin
      rx_ready_q <= 1'b0;
    end else begin
      rx_ready_q <= ~tx_valid & ~tx_start;
    end
  end

  // ----------------------------------------
  // millisecond tick
  // ----------------------------------------
  reg [31:0] div_q;
  reg tick_q;

  always @(posedge clk) begin
    if (!rstn) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (div_q == TICK_CYCLES - 1) begin
      div_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // profile timing
  // ----------------------------------------
  wire [15:0] adv_ms;
  wire [15:0] win_ms;
  wire [7:0] conn_s;
  wire [19:0] interval_ms;
  wire [15:0] conn_ms;
  wire [19:0] period_ms;

  assign adv_ms = ADV_TAB[scan_timing_profile_q[3:0] * 16 +: 16]; // [R4]
  assign win_ms = WIN_TAB[scan_timing_profile_q[3:0] * 16 +: 16]; // [R5]
  assign conn_s = CONN_TAB[scan_timing_profile_q[3:0] * 8 +: 8]; // [R7]
  assign interval_ms = {4'h0, win_ms} * {12'h000, scan_duty_factor_q}; // [R2]
  assign conn_ms = conn_s * `SAT_MS_PER_S; // [R7]
  assign period_ms = scan_mode ? interval_ms : {4'h0, adv_ms};

  // ----------------------------------------
  // scheduler
  // ----------------------------------------
  reg [19:0] phase_q;
  reg mode_q;
  wire wrap;

  assign wrap = tick_q && (phase_q + 20'h00001 >= period_ms);

  always @(posedge clk) begin
    if (!rstn) begin
      phase_q <= 20'h00000;
      mode_q <= 1'b0;
      adv_send_q <= 1'b0;
      chan_switch_q <= 1'b0;
      scan_on_q <= 1'b0;
    end else begin
      mode_q <= scan_mode;
      adv_send_q <= 1'b0;
      chan_switch_q <= 1'b0;
      if (mode_q != scan_mode) begin
        phase_q <= 20'h00000;
      end else if (wrap) begin
        phase_q <= 20'h00000;
        adv_send_q <= ~scan_mode; // [R4]
        chan_switch_q <= scan_mode; // [R6]
      end else if (tick_q) begin
        phase_q <= phase_q + 20'h00001;
      end
      scan_on_q <= scan_mode && (phase_q < {4'h0, win_ms}); // [R2] [R5]
    end
  end

  // ----------------------------------------
  // connection setup watch
  // ----------------------------------------
  reg [15:0] conn_left_q;

  always @(posedge clk) begin
    if (!rstn) begin
      conn_left_q <= 16'h0000;
      conn_pending_q <= 1'b0;
      conn_fail_q <= 1'b0;
    end else begin
      conn_fail_q <= 1'b0;
      if (conn_request) begin
        conn_left_q <= conn_ms; // [R7]
        conn_pending_q <= 1'b1;
      end else if (conn_pending_q && conn_answer) begin
        conn_pending_q <= 1'b0;
      end else if (conn_pending_q && tick_q) begin
        if (conn_left_q <= 16'h0001) begin
          conn_pending_q <= 1'b0;
          conn_fail_q <= 1'b1; // [R7]
        end else begin
          conn_left_q <= conn_left_q - 16'h0001;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* tb_scan_advert_timing_config.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_scan_advert_timing_config;
  localparam int T = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic scan_mode = 1'b0;
  logic conn_request = 1'b0;
  logic conn_answer = 1'b0;
  wire [7:0] rx_byte, tx_byte, prof, fac;
  wire rx_valid, rx_ready, tx_valid, tx_ready, adv, son, chs, cpend, cfail;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int n, m, p;
  int adv_ms [6] = '{20, 40, 60, 80, 100, 120};
  sat_top #(.TICK_CYCLES(T)) i_dut (
    .clk(clk), .rstn(rstn), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_ready_q(rx_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .scan_mode(scan_mode), .conn_request(conn_request),
    .conn_answer(conn_answer), .adv_send_q(adv), .scan_on_q(son),
    .chan_switch_q(chs), .conn_pending_q(cpend), .conn_fail_q(cfail),
    .scan_timing_profile_q(prof), .scan_duty_factor_q(fac)
  );
  sat_host_model i_host (
    .clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready_q(rx_ready),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready)
  );
  always #25 clk = ~clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task finish_test;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task rep_chk(input logic [7:0] cmd, input logic [7:0] st, input logic [7:0] v,
               input logic hv);
    logic [7:0] e [$];
    logic [7:0] cs;
    e = '{8'h02, cmd, hv ? 8'h02 : 8'h01, 8'h00, st};
    if (hv) e.push_back(v);
    cs = 8'h00;
    foreach (e[k]) cs ^= e[k];
    e.push_back(cs);
    chk(i_host.rep.size(), e.size());
    foreach (e[k]) chk(i_host.rep[k], e[k]);
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] v, input logic [7:0] st);
    i_host.xfer(8'h11, 16'h0002, idx, v, 1'b1, 1'b0);
    rep_chk(8'h51, st, 8'h00, 1'b0);
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] v, input logic ok);
    i_host.xfer(8'h10, 16'h0001, idx, 8'h00, 1'b0, 1'b0);
    rep_chk(8'h50, ok ? 8'h00 : 8'h01, v, ok);
  endtask
  task gap(input int s, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #2;
      c++;
    end while (!(s == 0 ? adv : s == 1 ? chs : s == 2 ? !son : s == 3 ? cfail : son)
               && c < 50000);
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    #2 rstn = 1'b1;
    rd(8'h0A, 8'h02, 1'b1);
    rd(8'h09, 8'h01, 1'b1);
    $display("test reset values done");
    i_host.slow = 1'b1;
    wr(8'h0A, 8'h03, 8'h00);
    chk(fac, 8'h03);
    wr(8'h0A, 8'h00, 8'h01);
    wr(8'h0A, 8'h0B, 8'h01);
    wr(8'h09, 8'h0C, 8'h01);
    wr(8'h08, 8'h00, 8'h01);
    i_host.xfer(8'h11, 16'h0001, 8'h0A, 8'h05, 1'b0, 1'b0);
    rep_chk(8'h51, 8'h01, 8'h00, 1'b0);
    i_host.xfer(8'h12, 16'h0001, 8'h0A, 8'h00, 1'b0, 1'b0);
    chk(i_host.rep.size(), 0);
    rd(8'h0A, 8'h03, 1'b1);
    rd(8'h08, 8'h00, 1'b0);
    i_host.xfer(8'h10, 16'h0001, 8'h0A, 8'h00, 1'b0, 1'b1);
    chk(i_host.rep.size(), 0);
    i_host.slow = 1'b0;
    $display("test access done");
    for (p = 0; p < 12; p++) begin
      wr(8'h09, p[7:0], 8'h00);
      chk(prof, p[7:0]);
      if (p < 6) begin
        gap(0, n);
        gap(0, n);
        chk(n, adv_ms[p] * T);
      end
    end
    $display("test profiles done");
    wr(8'h09, 8'h00, 8'h00);
    scan_mode = 1'b1;
    gap(1, n);
    gap(1, n);
    chk(n, 25 * 3 * T);
    gap(4, n);
    gap(2, n);
    chk(n, 25 * T);
    wr(8'h0A, 8'h01, 8'h00);
    chk(fac, 8'h01);
    gap(1, n);
    gap(1, n);
    chk(n, 25 * T);
    scan_mode = 1'b0;
    $display("test scanning done");
    conn_request = 1'b1;
    @(posedge clk);
    #2 conn_request = 1'b0;
    chk(cpend, 1'b1);
    gap(3, n);
    chk(n > 999 * T && n <= 1001 * T, 1);
    conn_request = 1'b1;
    @(posedge clk);
    #2 conn_request = 1'b0;
    repeat (20) @(posedge clk);
    #2 conn_answer = 1'b1;
    @(posedge clk);
    #2 conn_answer = 1'b0;
    m = 0;
    repeat (1002 * T) begin
      @(posedge clk);
      #2 m += cfail;
    end
    chk(m, 0);
    chk(cpend, 1'b0);
    $display("test connection done");
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #2 rstn = 1'b1;
    chk(prof, 8'h01);
    chk(fac, 8'h02);
    rd(8'h0A, 8'h02, 1'b1);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
`default_nettype wire
